// ===== rtl/psw_cfg.svh
// constants for the processor status word flag logic
// Summary of operation
// - end flag marks most negative source
// - zero flag set on zero result
// - carry arithmetic keeps zero flag chained
// - bit ops: zero is NOT/NOR of bits
// - overflow on signed add/sub/negate range
// - multiply/divide overflow; divide by zero
// - logical operations clear overflow
// - right shifts make overflow sticky
// - bit ops: overflow cleared or OR
// - addition carry from operand msb
// - subtract and compare carry is borrow
// - logical, multiply, divide clear carry
// - shift carry is last bit out
// - bit ops: carry cleared or AND
// - negative flag is result msb
// - bit ops: negative is bit or XOR
// - interrupted multiply flag set, restored
// - software write beats implicit flags
// - accepted interrupt level loads priority field
// - enable and level gate interrupt acceptance
// - bit ten enables bus arbitration pins
// - reset clears whole status word
`ifndef PSW_CFG_SVH
`define PSW_CFG_SVH
`define PSW_ADDR    16'hff10
`define PSW_RST     16'h0000
`define PSW_WMASK   16'hfc7f
`define PSW_MIN_W   16'h8000
`define PSW_MIN_B   8'h80
`define PSW_B_N     0
`define PSW_B_C     1
`define PSW_B_V     2
`define PSW_B_Z     3
`define PSW_B_E     4
`define PSW_B_MULDIV_INTERRUPTED_FLAG 5
`define PSW_B_USR   6
`define PSW_B_HOLD  10
`define PSW_B_IEN   11
`define PSW_LVL_LO  12
`endif

// ===== rtl/psw_pkg.sv
// types shared by the status word logic
package psw_pkg;
  // operation class reported by the alu datapath
  typedef enum logic [3:0] {
    PSW_OP_NONE  = 4'b0000,
    PSW_OP_ADD   = 4'b0001,
    PSW_OP_ADDC  = 4'b0010,
    PSW_OP_SUB   = 4'b0011,
    PSW_OP_SUBC  = 4'b0100,
    PSW_OP_NEG   = 4'b0101,
    PSW_OP_LOGIC = 4'b0110,
    PSW_OP_MOV   = 4'b0111,
    PSW_OP_MUL   = 4'b1000,
    PSW_OP_DIV   = 4'b1001,
    PSW_OP_SHL   = 4'b1010,
    PSW_OP_SHR   = 4'b1011,
    PSW_OP_PRIOR = 4'b1100,
    PSW_OP_BIT1  = 4'b1101,
    PSW_OP_BIT2  = 4'b1110
  } psw_op_e;
  typedef logic [15:0] psw_word_t;
endpackage

// ===== rtl/psw_flag_logic.sv
// status word register, alu flag generation and apb slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "psw_cfg.svh"
module psw_flag_logic
  import psw_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [15:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        alu_valid_i,
  input  wire psw_op_e     alu_op_i,
  input  wire logic        byte_op_i,
  input  wire logic [15:0] op_a_i,
  input  wire logic [15:0] op_b_i,
  input  wire logic [15:0] res_i,
  input  wire logic        shift_zero_i,
  input  wire logic        shift_last_i,
  input  wire logic        shift_sticky_i,
  input  wire logic        muldiv_ovf_i,
  input  wire logic        div_zero_i,
  input  wire logic        bit_a_i,
  input  wire logic        bit_b_i,
  input  wire logic        irq_enter_i,
  input  wire logic [3:0]  irq_lvl_i,
  input  wire logic        muldiv_pend_i,
  input  wire logic        interrupt_return_instruction_i,
  input  wire logic        interrupt_return_instruction_muldiv_interrupted_flag_i,
  input  wire logic        req_valid_i,
  input  wire logic [3:0]  req_lvl_i,
  input  wire logic        req_nmi_i,
  output logic             irq_grant_o,
  output logic      [15:0] psw_o,
  output logic             bus_arb_en_o
);

  logic [1:0]  rst_sync_reg;   // reset release synchroniser
  logic        rst_n;          // synchronised active-low reset
  psw_word_t   psw_reg;        // the status word
  psw_word_t   psw_next;       // its next value
  logic        pready_reg;     // apb ready, one cycle per access
  logic        pslverr_reg;    // apb error for unmapped address
  logic [31:0] prdata_reg;     // apb read data
  logic        grant_reg;      // interrupt acceptance decision
  logic        hold_en_reg;    // bus arbitration pin enable
  logic        hit;            // address decodes to the status word
  logic        sw_wr;          // software write completes this edge
  // adder operands and outputs
  logic [15:0] ax;
  logic [15:0] ay;
  logic        aci;
  logic [16:0] sum_w;
  logic [8:0]  sum_b;
  logic        a_carry;
  logic        a_ovf;
  // per-width views of the result
  logic [15:0] ares;
  logic        r_zero;
  logic        r_msb;
  logic        e_src;
  // implicit flag values
  logic        f_n;
  logic        f_c;
  logic        f_v;
  logic        f_z;
  logic        f_e;

  // reset released through two flops
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // address decode and write strobe
  always_comb begin
    if (paddr_i == `PSW_ADDR) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end
  assign sw_wr = psel_i & penable_i & pready_reg & pwrite_i & hit;

  // apb slave: one wait-free access cycle after setup
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      // setup cycle: prepare the answer
      pready_reg  <= 1'b1;
      pslverr_reg <= ~hit;
      // read shows state after the previous instruction
      prdata_reg  <= (hit && !pwrite_i) ? {16'h0000, psw_reg}
                                        : 32'h0000_0000;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // shared adder for add, subtract, compare and negate
  always_comb begin
    ax  = op_a_i;
    ay  = op_b_i;
    aci = 1'b0;
    case (alu_op_i)
      PSW_OP_ADDC: begin
        aci = psw_reg[`PSW_B_C];
      end
      PSW_OP_SUB: begin
        ay  = ~op_b_i;
        aci = 1'b1;
      end
      PSW_OP_SUBC: begin
        // carry flag holds a borrow, so invert it
        ay  = ~op_b_i;
        aci = ~psw_reg[`PSW_B_C];
      end
      PSW_OP_NEG: begin
        ax  = 16'h0000;
        ay  = ~op_a_i;
        aci = 1'b1;
      end
      default: begin
        aci = 1'b0;
      end
    endcase
    sum_w = {1'b0, ax} + {1'b0, ay} + {16'h0000, aci};
    sum_b = {1'b0, ax[7:0]} + {1'b0, ay[7:0]} + {8'h00, aci};
    if (byte_op_i) begin
      ares    = {8'h00, sum_b[7:0]};
      a_carry = sum_b[8];
      a_ovf   = (ax[7] == ay[7]) && (sum_b[7] != ax[7]);
    end else begin
      ares    = sum_w[15:0];
      a_carry = sum_w[16];
      a_ovf   = (ax[15] == ay[15]) && (sum_w[15] != ax[15]);
    end
  end

  // zero, sign and end tests at the operand width
  always_comb begin
    logic [15:0] r;
    logic [15:0] s;
    r = res_i;
    s = (alu_op_i == PSW_OP_NEG) ? op_a_i : op_b_i;
    if (alu_op_i inside {PSW_OP_ADD, PSW_OP_ADDC, PSW_OP_SUB,
                         PSW_OP_SUBC, PSW_OP_NEG}) begin
      r = ares;
    end
    if (byte_op_i) begin
      r_zero = (r[7:0] == 8'h00);
      r_msb  = r[7];
      e_src  = (s[7:0] == `PSW_MIN_B);
    end else begin
      r_zero = (r == 16'h0000);
      r_msb  = r[15];
      e_src  = (s == `PSW_MIN_W);
    end
  end

  // implicit flags per operation class
  always_comb begin
    f_n = r_msb;
    f_z = r_zero;
    f_c = 1'b0;
    f_v = 1'b0;
    f_e = 1'b0;
    case (alu_op_i)
      PSW_OP_ADD: begin
        f_c = a_carry;
        f_v = a_ovf;
        f_e = e_src;
      end
      PSW_OP_ADDC: begin
        f_c = a_carry;
        f_v = a_ovf;
        f_e = e_src;
        f_z = r_zero & psw_reg[`PSW_B_Z];
      end
      PSW_OP_SUB, PSW_OP_NEG: begin
        f_c = ~a_carry;
        f_v = a_ovf;
        f_e = e_src;
      end
      PSW_OP_SUBC: begin
        f_c = ~a_carry;
        f_v = a_ovf;
        f_e = e_src;
        f_z = r_zero & psw_reg[`PSW_B_Z];
      end
      PSW_OP_LOGIC, PSW_OP_MOV: begin
        // carry and overflow cleared
        f_e = e_src;
      end
      PSW_OP_MUL, PSW_OP_DIV: begin
        // carry cleared, overflow on range or zero divisor
        f_v = muldiv_ovf_i | (alu_op_i == PSW_OP_DIV & div_zero_i);
      end
      PSW_OP_SHL: begin
        f_c = shift_last_i & ~shift_zero_i;
      end
      PSW_OP_SHR: begin
        f_c = shift_last_i & ~shift_zero_i;
        f_v = shift_sticky_i & ~shift_zero_i;
      end
      PSW_OP_PRIOR: begin
        // normalising never shifts a one out
        f_c = 1'b0;
      end
      PSW_OP_BIT1: begin
        f_z = ~bit_a_i;
        f_n = bit_a_i;
      end
      PSW_OP_BIT2: begin
        f_z = ~(bit_a_i | bit_b_i);
        f_v = bit_a_i | bit_b_i;
        f_c = bit_a_i & bit_b_i;
        f_n = bit_a_i ^ bit_b_i;
      end
      default: begin
        f_n = psw_reg[`PSW_B_N];
        f_z = psw_reg[`PSW_B_Z];
        f_c = psw_reg[`PSW_B_C];
        f_v = psw_reg[`PSW_B_V];
        f_e = psw_reg[`PSW_B_E];
      end
    endcase
  end

  // next status word: software write wins over everything
  always_comb begin
    psw_next = psw_reg;
    if (alu_valid_i) begin
      psw_next[`PSW_B_E:`PSW_B_N] = {f_e, f_z, f_v, f_c, f_n};
    end
    if (irq_enter_i) begin
      psw_next[15:`PSW_LVL_LO]  = irq_lvl_i;
      psw_next[`PSW_B_MULDIV_INTERRUPTED_FLAG]    = muldiv_pend_i;
    end else if (interrupt_return_instruction_i) begin
      psw_next[`PSW_B_MULDIV_INTERRUPTED_FLAG]    = interrupt_return_instruction_muldiv_interrupted_flag_i;
    end
    if (sw_wr) begin
      psw_next = pwdata_i[15:0] & `PSW_WMASK;
    end
  end

  // status word register
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      psw_reg <= `PSW_RST;
    end else begin
      psw_reg <= psw_next;
    end
  end

  // interrupt acceptance gate
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      grant_reg <= 1'b0;
    end else begin
      // level 15 cannot be exceeded, so only nmi/traps pass
      grant_reg <= req_valid_i & (req_nmi_i |
                   (psw_reg[`PSW_B_IEN] &
                    (req_lvl_i > psw_reg[15:`PSW_LVL_LO])));
    end
  end

  // arbitration pin enable follows bit ten
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_en_reg <= 1'b0;
    end else begin
      hold_en_reg <= psw_next[`PSW_B_HOLD];
    end
  end

  assign prdata_o     = prdata_reg;
  assign pready_o     = pready_reg;
  assign pslverr_o    = pslverr_reg;
  assign irq_grant_o  = grant_reg;
  assign psw_o        = psw_reg;
  assign bus_arb_en_o = hold_en_reg;

  // checks on the flag logic
  a_reset_clear: assert property (
    @(posedge clk_sys_i) !rst_n |-> psw_reg == `PSW_RST)
    else $error("status word not cleared in reset");
  a_reserved_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n) psw_reg[9:7] == 3'b000)
    else $error("reserved bits not zero");
  a_logic_flags: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    alu_valid_i && alu_op_i == PSW_OP_LOGIC && !byte_op_i && !sw_wr
    |=> !psw_reg[`PSW_B_V] && !psw_reg[`PSW_B_C] &&
        psw_reg[`PSW_B_Z] == ($past(res_i) == 16'h0000))
    else $error("logical flags wrong");
  a_addc_chain: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    alu_valid_i && alu_op_i == PSW_OP_ADDC && !psw_reg[`PSW_B_Z] && !sw_wr
    |=> !psw_reg[`PSW_B_Z])
    else $error("zero chain broken");
  a_bit_two: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    alu_valid_i && alu_op_i == PSW_OP_BIT2 && !sw_wr
    |=> psw_reg[`PSW_B_C] == ($past(bit_a_i) & $past(bit_b_i)) &&
        psw_reg[`PSW_B_V] == ($past(bit_a_i) | $past(bit_b_i)))
    else $error("two bit flags wrong");
  a_div_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    alu_valid_i && alu_op_i == PSW_OP_DIV && div_zero_i && !sw_wr
    |=> psw_reg[`PSW_B_V] && !psw_reg[`PSW_B_C])
    else $error("divide by zero without overflow");
  a_sw_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    sw_wr |=> psw_reg == ($past(pwdata_i[15:0]) & `PSW_WMASK))
    else $error("software write lost");
  a_irq_level: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    irq_enter_i && !sw_wr |=> psw_reg[15:`PSW_LVL_LO] == $past(irq_lvl_i))
    else $error("priority not loaded");
  a_grant_gate: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    !psw_reg[`PSW_B_IEN] && !req_nmi_i |=> !irq_grant_o)
    else $error("grant while disabled");
  a_apb_ready: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("ready timing wrong");
  c_add: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    alu_valid_i && alu_op_i == PSW_OP_ADD);
  c_irq: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    irq_enter_i && muldiv_pend_i ##[1:20] interrupt_return_instruction_i);
  c_write: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    sw_wr && alu_valid_i);
  c_grant: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    irq_grant_o);

endmodule
`default_nettype wire

// ===== test/psw_dp_model.sv
// datapath model feeding operands and results to the flag logic
`timescale 1ns/1ps
`default_nettype none
module psw_dp_model
  import psw_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        go_i,
  input  wire psw_op_e     op_i,
  input  wire logic        byte_i,
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  input  wire logic [3:0]  cnt_i,
  output logic             alu_valid_o,
  output psw_op_e          alu_op_o,
  output logic             byte_op_o,
  output logic      [15:0] op_a_o,
  output logic      [15:0] op_b_o,
  output logic      [15:0] res_o,
  output logic             shift_zero_o,
  output logic             shift_last_o,
  output logic             shift_sticky_o,
  output logic             muldiv_ovf_o,
  output logic             div_zero_o,
  output logic             bit_a_o,
  output logic             bit_b_o
);
  logic [31:0] sr; // right shift window: result over lost bits
  logic [31:0] sl; // left shift window: lost bit over result
  logic [31:0] pr; // full product
  // barrel shifter and multiplier
  always_comb begin
    sr = {a_i, 16'h0} >> cnt_i;
    sl = {16'h0, a_i} << cnt_i;
    pr = a_i * b_i;
  end
  // one-cycle completion; idle data lines keep toggling
  always_ff @(posedge clk_sys_i) begin
    alu_valid_o <= go_i;
    if (go_i) begin
      alu_op_o <= op_i;
      byte_op_o <= byte_i;
      op_a_o <= a_i;
      op_b_o <= b_i;
      shift_zero_o <= (cnt_i == 4'h0);
      shift_last_o <= (op_i == PSW_OP_SHL) ? sl[16] : sr[15];
      shift_sticky_o <= |sr[14:0];
      muldiv_ovf_o <= (op_i == PSW_OP_MUL) ? |pr[31:16] : (b_i == 16'h0);
      div_zero_o <= (b_i == 16'h0);
      bit_a_o <= a_i[0];
      bit_b_o <= b_i[0];
      case (op_i)
        PSW_OP_MOV: res_o <= b_i;
        PSW_OP_MUL: res_o <= pr[15:0];
        PSW_OP_DIV: res_o <= (b_i == 16'h0) ? 16'hffff : a_i / b_i;
        PSW_OP_SHL: res_o <= sl[15:0];
        PSW_OP_SHR: res_o <= sr[31:16];
        PSW_OP_PRIOR: res_o <= a_i;
        default: res_o <= a_i & b_i;
      endcase
    end else begin
      op_a_o <= ~op_a_o;
      op_b_o <= ~op_b_o;
      res_o <= ~res_o;
    end
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the status word flag logic
`timescale 1ns/1ps
`default_nettype none
`include "psw_cfg.svh"
module testbench import psw_pkg::*;;
  logic clk_sys = 0, rst_b = 1, psel = 0, pen = 0, pwr = 0;
  logic [15:0] paddr = 0, a = 0, b = 0, res, opa, opb;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, grant, arb, go = 0, byt = 0, av, bo;
  logic sz, sl, ss, mo, dz, ba, bb;
  logic [15:0] psw; // status word seen at the port
  psw_op_e op = PSW_OP_NONE, aop;
  logic [3:0] cnt = 0, cpu_priority_level = 0, rlvl = 0;
  logic ienter = 0, mpend = 0, interrupt_return_instruction = 0, rmul = 0, rval = 0, rnmi = 0;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  psw_flag_logic i_psw_flag_logic (.clk_sys_i(clk_sys), .rst_b_i(rst_b),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .alu_valid_i(av), .alu_op_i(aop), .byte_op_i(bo),
    .op_a_i(opa), .op_b_i(opb), .res_i(res), .shift_zero_i(sz),
    .shift_last_i(sl), .shift_sticky_i(ss), .muldiv_ovf_i(mo),
    .div_zero_i(dz), .bit_a_i(ba), .bit_b_i(bb), .irq_enter_i(ienter),
    .irq_lvl_i(cpu_priority_level), .muldiv_pend_i(mpend), .interrupt_return_instruction_i(interrupt_return_instruction),
    .interrupt_return_instruction_muldiv_interrupted_flag_i(rmul), .req_valid_i(rval), .req_lvl_i(rlvl),
    .req_nmi_i(rnmi), .irq_grant_o(grant), .psw_o(psw),
    .bus_arb_en_o(arb));
  psw_dp_model i_psw_dp_model (.clk_sys_i(clk_sys), .go_i(go), .op_i(op),
    .byte_i(byt), .a_i(a), .b_i(b), .cnt_i(cnt), .alu_valid_o(av),
    .alu_op_o(aop), .byte_op_o(bo), .op_a_o(opa), .op_b_o(opb),
    .res_o(res), .shift_zero_o(sz), .shift_last_o(sl),
    .shift_sticky_o(ss), .muldiv_ovf_o(mo), .div_zero_o(dz),
    .bit_a_o(ba), .bit_b_o(bb));
  // 50 mhz clock
  always #10 clk_sys = ~clk_sys;
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [15:0] ad,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge clk_sys);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk_sys);
    pen <= 1;
    // wait ends when pready is seen; the hang guard ends the run if it never comes
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  // write, checking the error flag
  task automatic wr(input logic [15:0] ad, input logic [31:0] wd,
                    input logic ee);
    logic [31:0] d;
    logic er;
    apb(1, ad, wd, d, er);
    chk("wr pslverr", {31'h0, ee}, {31'h0, er});
  endtask
  // read and compare data and error
  task automatic rdc(input logic [15:0] ad, input logic [31:0] e,
                     input logic ee);
    logic [31:0] d;
    logic er;
    apb(0, ad, 32'h0, d, er);
    chk("prdata", e, d);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask
  // issue one op through the datapath, compare masked flags
  task automatic alu(input psw_op_e o, input logic bm,
                     input logic [15:0] x, y, input logic [3:0] c,
                     input logic [4:0] e, m);
    @(posedge clk_sys);
    go <= 1;
    op <= o;
    byt <= bm;
    a <= x;
    b <= y;
    cnt <= c;
    @(posedge clk_sys);
    go <= 0;
    @(posedge clk_sys);
    #1;
    chk("flags", {27'h0, e & m}, {27'h0, psw[4:0] & m});
  endtask
  // one interrupt request, grant checked a cycle later
  task automatic req(input logic [3:0] lv, input logic nm, input logic e);
    @(posedge clk_sys);
    rval <= 1;
    rlvl <= lv;
    rnmi <= nm;
    @(posedge clk_sys);
    rval <= 0;
    #1;
    chk("grant", {31'h0, e}, {31'h0, grant});
  endtask
  task automatic t_regs;
    chk("psw", 32'h0, {16'h0, psw});
    rdc(`PSW_ADDR, 32'h0, 0);
    wr(`PSW_ADDR, 32'hffffffff, 0);
    rdc(`PSW_ADDR, 32'h0000fc7f, 0);
    chk("arb_en", 32'h1, {31'h0, arb});
    wr(16'hff12, 32'h0, 1);
    rdc(16'hff12, 32'h0, 1);
    wr(`PSW_ADDR, 32'h0, 0);
    rdc(`PSW_ADDR, 32'h0, 0);
    chk("arb_en", 32'h0, {31'h0, arb});
    $display("register test done");
  endtask
  task automatic t_alu;
    alu(PSW_OP_ADD, 0, 16'h7fff, 16'h0001, 0, 5'h05, 5'h1f);
    alu(PSW_OP_ADD, 0, 16'hffff, 16'h0001, 0, 5'h0a, 5'h1f);
    alu(PSW_OP_ADDC, 0, 16'h0000, 16'hffff, 0, 5'h0a, 5'h1f);
    alu(PSW_OP_SUBC, 0, 16'h0001, 16'h0000, 0, 5'h08, 5'h1f);
    alu(PSW_OP_ADD, 0, 16'h0001, 16'h0001, 0, 5'h00, 5'h1f);
    alu(PSW_OP_ADDC, 0, 16'h0000, 16'h0000, 0, 5'h00, 5'h1f);
    alu(PSW_OP_SUB, 0, 16'h0000, 16'h0001, 0, 5'h03, 5'h1f);
    alu(PSW_OP_DIV, 0, 16'h0005, 16'h0000, 0, 5'h04, 5'h1e);
    alu(PSW_OP_SUB, 0, 16'h0000, 16'h8000, 0, 5'h17, 5'h1f);
    alu(PSW_OP_NEG, 0, 16'h8000, 16'h0000, 0, 5'h15, 5'h1d);
    alu(PSW_OP_LOGIC, 0, 16'hffff, 16'h8000, 0, 5'h11, 5'h1f);
    alu(PSW_OP_MOV, 0, 16'h0000, 16'h0000, 0, 5'h08, 5'h1f);
    alu(PSW_OP_MOV, 1, 16'h0000, 16'h0080, 0, 5'h11, 5'h1f);
    alu(PSW_OP_MUL, 0, 16'h0100, 16'h0100, 0, 5'h0c, 5'h1f);
    alu(PSW_OP_SHR, 0, 16'h0007, 16'h0000, 2, 5'h06, 5'h1f);
    alu(PSW_OP_SHR, 0, 16'h0006, 16'h0000, 2, 5'h02, 5'h1f);
    alu(PSW_OP_SHR, 0, 16'h0007, 16'h0000, 0, 5'h00, 5'h1f);
    alu(PSW_OP_SHL, 0, 16'h8001, 16'h0000, 1, 5'h02, 5'h1f);
    alu(PSW_OP_PRIOR, 0, 16'h0000, 16'h0000, 0, 5'h08, 5'h1b);
    alu(PSW_OP_ADD, 1, 16'h007f, 16'h0001, 0, 5'h05, 5'h1f);
    alu(PSW_OP_ADD, 1, 16'h00ff, 16'h0001, 0, 5'h0a, 5'h1f);
    $display("alu flag test done");
  endtask
  task automatic t_bits;
    logic x;
    logic y;
    for (int i = 0; i < 4; i++) begin
      x = i[1];
      y = i[0];
      alu(PSW_OP_BIT2, 0, {15'h0, x}, {15'h0, y}, 0,
          {1'b0, ~(x | y), x | y, x & y, x ^ y}, 5'h1f);
      alu(PSW_OP_BIT1, 0, {15'h0, y}, 16'h0, 0,
          {1'b0, ~y, 1'b0, 1'b0, y}, 5'h1f);
    end
    $display("bit operation test done");
  endtask
  task automatic t_irq;
    wr(`PSW_ADDR, 32'h5800, 0);
    #1;
    chk("level", 32'h5, {28'h0, psw[15:12]});
    req(4'h5, 0, 0);
    req(4'h6, 0, 1);
    req(4'h0, 1, 1);
    wr(`PSW_ADDR, 32'hf800, 0);
    req(4'hf, 0, 0);
    req(4'hf, 1, 1);
    wr(`PSW_ADDR, 32'h0, 0);
    req(4'hf, 0, 0);
    @(posedge clk_sys);
    ienter <= 1;
    cpu_priority_level <= 4'h9;
    mpend <= 1;
    @(posedge clk_sys);
    ienter <= 0;
    #1;
    chk("level", 32'h9, {28'h0, psw[15:12]});
    chk("muldiv_interrupted_flag", 32'h1, {31'h0, psw[`PSW_B_MULDIV_INTERRUPTED_FLAG]});
    @(posedge clk_sys);
    interrupt_return_instruction <= 1;
    rmul <= 0;
    @(posedge clk_sys);
    interrupt_return_instruction <= 0;
    #1;
    chk("muldiv_interrupted_flag", 32'h0, {31'h0, psw[`PSW_B_MULDIV_INTERRUPTED_FLAG]});
    $display("interrupt test done");
  endtask
  // reset in mid-run clears the whole word
  task automatic t_reset;
    wr(`PSW_ADDR, 32'hffff, 0);
    #1;
    chk("psw", 32'h0000fc7f, {16'h0, psw});
    @(posedge clk_sys);
    rst_b <= 0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("psw", 32'h0, {16'h0, psw});
    chk("arb_en", 32'h0, {31'h0, arb});
    @(posedge clk_sys);
    rst_b <= 1;
    repeat (3) @(posedge clk_sys);
    rdc(`PSW_ADDR, 32'h0, 0);
    $display("reset test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      final_report;
    end
  end
  initial begin
    // falling edge at time zero so the async clear really fires
    rst_b <= 0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    t_alu;
    t_bits;
    t_irq;
    t_reset;
    final_report;
  end
endmodule
`default_nettype wire
